// file: src/dtf_pkg.sv
// Constants, codes and timing for the drive trip fault manager.
// Assumes a single 250 MHz core clock and an asynchronous active-low reset.
package dtf_pkg;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned SELFTEST_MS      = 1000;
  localparam int unsigned CLEAR_HOLD_MS    = 3000;
  localparam int unsigned SELFTEST_CYCLES  = SELFTEST_MS * 1000 * CLK_MHZ;
  localparam int unsigned CLEAR_CYCLES     = CLEAR_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W            = 30;
  localparam int unsigned BUS_W            = 12;
  localparam int unsigned PCT_FULL         = 100;
  localparam int unsigned PCT_BYPASS       = 90;
  localparam int unsigned HIST_DEPTH       = 3;
  localparam int unsigned IDX_W            = 2;

  typedef enum logic [3:0] {
    DTF_CODE_NONE  = 4'h0,
    DTF_CODE_HV    = 4'h1,
    DTF_CODE_LV    = 4'h2,
    DTF_CODE_OC_A  = 4'h3,
    DTF_CODE_OC_D  = 4'h4,
    DTF_CODE_OC_G  = 4'h5,
    DTF_CODE_OC    = 4'h6,
    DTF_CODE_OL    = 4'h7,
    DTF_CODE_ARM   = 4'h8
  } dtf_code_type;

  localparam logic [3:0] DISP_SHOW_CODE  = 4'h1;
  localparam logic [3:0] DISP_SHOW_SELF  = 4'h2;
  localparam logic [3:0] DISP_SHOW_ZERO  = 4'h3;
  localparam logic [3:0] DISP_SHOW_HIST  = 4'h4;
  localparam logic [3:0] DISP_SHOW_RUN   = 4'h0;

  typedef enum logic [4:0] {
    DTF_ST_TEST  = 5'h01,
    DTF_ST_FAIL  = 5'h02,
    DTF_ST_STOP  = 5'h04,
    DTF_ST_RUN   = 5'h08,
    DTF_ST_TRIP  = 5'h10
  } dtf_state_type;
endpackage

// file: src/dtf_trip_manager.sv
// Trip detection, fault history, self-test timing and relay sequencing.
// Assumes keys and current, overload and leakage flags are asynchronous pins; bus-level and accel/decel flags and bus voltage arrive in-clock.
`timescale 1ns/100ps
module dtf_trip_manager #(
  parameter int unsigned SELFTEST_CYCLES = dtf_pkg::SELFTEST_CYCLES,
  parameter int unsigned CLEAR_CYCLES    = dtf_pkg::CLEAR_CYCLES
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic [dtf_pkg::BUS_W-1:0] bus_voltage_in,
  input  wire logic [dtf_pkg::BUS_W-1:0] bus_rated_in,
  input  wire logic                      selftest_pass_in,
  input  wire logic [7:0]                selftest_code_in,
  input  wire logic                      high_bus_in,
  input  wire logic                      low_bus_in,
  input  wire logic                      accelerating_in,
  input  wire logic                      decelerating_in,
  input  wire logic                      output_overcurrent_in,
  input  wire logic                      output_overload_in,
  input  wire logic                      leakage_fault_in,
  input  wire logic                      bus_current_fault_in,
  input  wire logic                      start_key_in,
  input  wire logic                      stop_key_in,
  input  wire logic                      monitor_key_in,
  input  wire logic                      up_key_in,
  input  wire logic                      down_key_in,
  input  wire logic                      program_enable_jumper_position_in,
  input  wire logic                      config_write_in,
  output logic                           precharge_bypass_relay_out,
  output logic                           fault_relay_out,
  output logic                           drive_enable_out,
  output logic                           ready_out,
  output logic                           config_write_ok_out,
  output logic [3:0]                     display_mode_out,
  output logic [3:0]                     display_code_out,
  output logic [7:0]                     two_digit_code_out,
  output logic [dtf_pkg::IDX_W-1:0]      history_index_out
);
  localparam int unsigned NSYNC = 12;

  // Three-stage synchronisers; second and third must agree
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] clean_reg;
  logic [NSYNC-1:0] clean_next;
  logic [NSYNC-1:0] raw;

  assign raw = {config_write_in, program_enable_jumper_position_in, down_key_in, up_key_in,
                monitor_key_in, stop_key_in, start_key_in, bus_current_fault_in,
                leakage_fault_in, output_overload_in, output_overcurrent_in, selftest_pass_in};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_comb begin
        clean_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : clean_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      clean_reg <= '0;
    end else begin
      s1_reg    <= raw;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      clean_reg <= clean_next;
    end
  end

  logic st_pass;
  logic f_oc;
  logic f_ol;
  logic f_leak;
  logic f_arm;
  logic k_start;
  logic k_stop;
  logic k_mon;
  logic k_up;
  logic k_down;
  logic jumper;
  logic cfg_wr;
  assign {cfg_wr, jumper, k_down, k_up, k_mon, k_stop, k_start, f_arm, f_leak, f_ol, f_oc, st_pass} = clean_reg;

  // Previous key levels for edge detection, taken by name so no bit position can slip
  logic p_start_reg;
  logic p_stop_reg;
  logic p_mon_reg;
  logic p_up_reg;
  logic p_down_reg;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      p_start_reg <= 1'b0;
      p_stop_reg  <= 1'b0;
      p_mon_reg   <= 1'b0;
      p_up_reg    <= 1'b0;
      p_down_reg  <= 1'b0;
    end else begin
      p_start_reg <= k_start;
      p_stop_reg  <= k_stop;
      p_mon_reg   <= k_mon;
      p_up_reg    <= k_up;
      p_down_reg  <= k_down;
    end
  end

  logic start_rise;
  logic stop_rise;
  logic stop_fall;
  logic mon_rise;
  logic up_rise;
  logic down_rise;
  assign start_rise = k_start & ~p_start_reg;
  assign stop_rise  = k_stop & ~p_stop_reg;
  assign stop_fall  = ~k_stop & p_stop_reg;
  assign mon_rise   = k_mon & ~p_mon_reg;
  assign up_rise    = k_up & ~p_up_reg;
  assign down_rise  = k_down & ~p_down_reg;

  // Fault encoder in priority order
  function automatic dtf_pkg::dtf_code_type fault_code(input logic hv, input logic lv, input logic oc,
                                                       input logic ol, input logic leak, input logic arm,
                                                       input logic acc, input logic dec);
    dtf_pkg::dtf_code_type c;
    c = dtf_pkg::DTF_CODE_NONE;
    if (leak) c = dtf_pkg::DTF_CODE_OC_G;
    else if (arm) c = dtf_pkg::DTF_CODE_ARM;
    else if (oc && acc) c = dtf_pkg::DTF_CODE_OC_A;
    else if (oc && dec) c = dtf_pkg::DTF_CODE_OC_D;
    else if (oc) c = dtf_pkg::DTF_CODE_OC;
    else if (ol) c = dtf_pkg::DTF_CODE_OL;
    else if (hv) c = dtf_pkg::DTF_CODE_HV;
    else if (lv) c = dtf_pkg::DTF_CODE_LV;
    return c;
  endfunction

  // Bus-level comparator flags come from same-clock logic
  dtf_pkg::dtf_code_type cur_code;
  assign cur_code = fault_code(high_bus_in, low_bus_in, f_oc, f_ol, f_leak, f_arm,
                               accelerating_in, decelerating_in);
  logic fault_active;
  assign fault_active = (cur_code != dtf_pkg::DTF_CODE_NONE);

  dtf_pkg::dtf_state_type state_reg;
  dtf_pkg::dtf_state_type state_next;
  logic [dtf_pkg::CNT_W-1:0] cnt_reg;
  logic [dtf_pkg::CNT_W-1:0] cnt_next;
  logic [3:0] hist_reg [dtf_pkg::HIST_DEPTH];
  logic [3:0] hist_next [dtf_pkg::HIST_DEPTH];
  logic [3:0] first_reg;
  logic [3:0] first_next;
  logic [dtf_pkg::IDX_W-1:0] idx_reg;
  logic [dtf_pkg::IDX_W-1:0] idx_next;
  logic view_reg;
  logic view_next;
  logic cleared_reg;
  logic cleared_next;
  logic relay_reg;
  logic relay_next;
  logic [7:0] two_reg;
  logic [7:0] two_next;
  logic [3:0] mode_reg;
  logic [3:0] mode_next;
  logic [3:0] dcode_reg;
  logic [3:0] dcode_next;
  logic cfg_ok_reg;
  logic cfg_ok_next;
  logic [dtf_pkg::BUS_W+7:0] v_scaled;
  logic [dtf_pkg::BUS_W+7:0] r_scaled;

  assign v_scaled = (dtf_pkg::BUS_W+8)'(bus_voltage_in) * (dtf_pkg::BUS_W+8)'(dtf_pkg::PCT_FULL);
  assign r_scaled = (dtf_pkg::BUS_W+8)'(bus_rated_in) * (dtf_pkg::BUS_W+8)'(dtf_pkg::PCT_BYPASS);

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    hist_next    = hist_reg;
    first_next   = first_reg;
    idx_next     = idx_reg;
    view_next    = view_reg;
    cleared_next = cleared_reg;
    relay_next   = relay_reg | (v_scaled >= r_scaled);
    two_next     = two_reg;
    case (state_reg)
      dtf_pkg::DTF_ST_TEST: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= (dtf_pkg::CNT_W)'(SELFTEST_CYCLES - 1)) begin
          cnt_next = '0;
          if (st_pass) state_next = dtf_pkg::DTF_ST_STOP;
          else begin
            state_next = dtf_pkg::DTF_ST_FAIL;
            two_next   = selftest_code_in;
          end
        end
      end
      dtf_pkg::DTF_ST_FAIL: state_next = dtf_pkg::DTF_ST_FAIL;
      dtf_pkg::DTF_ST_STOP: begin
        if (fault_active) state_next = dtf_pkg::DTF_ST_TRIP;
        else if (start_rise) begin
          state_next = dtf_pkg::DTF_ST_RUN;
          view_next  = 1'b0;
        end else if (mon_rise) begin
          view_next = 1'b1;
          idx_next  = '0;
        end else if (view_reg && up_rise && idx_reg != '0) idx_next = idx_reg - 1'b1;
        else if (view_reg && down_rise && idx_reg != (dtf_pkg::IDX_W)'(dtf_pkg::HIST_DEPTH - 1))
          idx_next = idx_reg + 1'b1;
      end
      dtf_pkg::DTF_ST_RUN: begin
        if (fault_active) state_next = dtf_pkg::DTF_ST_TRIP;
        else if (stop_rise) state_next = dtf_pkg::DTF_ST_STOP;
      end
      dtf_pkg::DTF_ST_TRIP: begin
        if (state_reg != state_next) cnt_next = '0;
        if (k_stop && !cleared_reg) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg >= (dtf_pkg::CNT_W)'(CLEAR_CYCLES - 1)) begin
            cleared_next = 1'b1;
            for (int i = 0; i < dtf_pkg::HIST_DEPTH; i++) hist_next[i] = dtf_pkg::DTF_CODE_NONE;
          end
        end else cnt_next = '0;
        if (stop_fall && !fault_active) begin
          state_next   = dtf_pkg::DTF_ST_STOP;
          cleared_next = 1'b0;
          first_next   = dtf_pkg::DTF_CODE_NONE;
        end
      end
      default: state_next = dtf_pkg::DTF_ST_TEST;
    endcase
    if ((state_reg == dtf_pkg::DTF_ST_STOP || state_reg == dtf_pkg::DTF_ST_RUN) && fault_active) begin
      first_next = cur_code;
      cnt_next   = '0;
      hist_next[0] = cur_code;
      for (int i = 1; i < dtf_pkg::HIST_DEPTH; i++) hist_next[i] = hist_reg[i-1];
    end
    // Judged on the next state so a grant never overlaps run or trip
    cfg_ok_next  = cfg_wr & jumper & (state_next == dtf_pkg::DTF_ST_STOP);
    case (state_next)
      dtf_pkg::DTF_ST_FAIL: begin
        mode_next  = dtf_pkg::DISP_SHOW_SELF;
        dcode_next = dtf_pkg::DTF_CODE_NONE;
      end
      dtf_pkg::DTF_ST_TRIP: begin
        mode_next  = cleared_next ? dtf_pkg::DISP_SHOW_ZERO : dtf_pkg::DISP_SHOW_CODE;
        dcode_next = cleared_next ? dtf_pkg::DTF_CODE_NONE : first_next;
      end
      dtf_pkg::DTF_ST_STOP: begin
        mode_next  = view_next ? dtf_pkg::DISP_SHOW_HIST : dtf_pkg::DISP_SHOW_RUN;
        dcode_next = view_next ? hist_next[idx_next] : dtf_pkg::DTF_CODE_NONE;
      end
      default: begin
        mode_next  = dtf_pkg::DISP_SHOW_RUN;
        dcode_next = dtf_pkg::DTF_CODE_NONE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg   <= dtf_pkg::DTF_ST_TEST;
      cnt_reg     <= '0;
      for (int i = 0; i < dtf_pkg::HIST_DEPTH; i++) hist_reg[i] <= dtf_pkg::DTF_CODE_NONE;
      first_reg   <= dtf_pkg::DTF_CODE_NONE;
      idx_reg     <= '0;
      view_reg    <= 1'b0;
      cleared_reg <= 1'b0;
      relay_reg   <= 1'b0;
      two_reg     <= 8'h00;
      mode_reg    <= dtf_pkg::DISP_SHOW_RUN;
      dcode_reg   <= dtf_pkg::DTF_CODE_NONE;
      cfg_ok_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      hist_reg    <= hist_next;
      first_reg   <= first_next;
      idx_reg     <= idx_next;
      view_reg    <= view_next;
      cleared_reg <= cleared_next;
      relay_reg   <= relay_next;
      two_reg     <= two_next;
      mode_reg    <= mode_next;
      dcode_reg   <= dcode_next;
      cfg_ok_reg  <= cfg_ok_next;
    end
  end

  // Output flops
  logic fault_q;
  logic drive_q;
  logic ready_q;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_q <= 1'b0;
      drive_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      fault_q <= (state_next == dtf_pkg::DTF_ST_TRIP);
      drive_q <= (state_next == dtf_pkg::DTF_ST_RUN);
      ready_q <= (state_next == dtf_pkg::DTF_ST_STOP) || (state_next == dtf_pkg::DTF_ST_RUN);
    end
  end

  assign precharge_bypass_relay_out = relay_reg;
  assign fault_relay_out            = fault_q;
  assign drive_enable_out           = drive_q;
  assign ready_out                  = ready_q;
  assign config_write_ok_out        = cfg_ok_reg;
  assign display_mode_out           = mode_reg;
  assign display_code_out           = dcode_reg;
  assign two_digit_code_out         = two_reg;
  assign history_index_out          = idx_reg;
endmodule

// file: bench/dtf_chk.sv
// Port-level assertions for the trip manager.
// Assumes one clock domain and the async active-low reset of the core.
`timescale 1ns/100ps
module dtf_chk #(
  parameter int unsigned SELFTEST_CYCLES = 50
) (
  input wire logic                      core_clk_in,
  input wire logic                      reset_n_in,
  input wire logic [dtf_pkg::BUS_W-1:0] bus_voltage_in,
  input wire logic [dtf_pkg::BUS_W-1:0] bus_rated_in,
  input wire logic                      precharge_bypass_relay_out,
  input wire logic                      fault_relay_out,
  input wire logic                      drive_enable_out,
  input wire logic                      ready_out,
  input wire logic                      config_write_ok_out,
  input wire logic [3:0]                display_mode_out,
  input wire logic [3:0]                display_code_out,
  input wire logic [dtf_pkg::IDX_W-1:0] history_index_out
);
  logic [31:0] up_reg;
  logic [31:0] up_next;
  // Cycles since reset release
  always_comb up_next = up_reg + 32'h1;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) up_reg <= 32'h0;
    else up_reg <= up_next;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_byp_hold; precharge_bypass_relay_out |=> precharge_bypass_relay_out; endproperty
  a_byp_hold: assert property (p_byp_hold) else $error("bypass relay dropped");
  property p_byp_cause;
    $rose(precharge_bypass_relay_out) |-> 32'($past(bus_voltage_in)) * 100 >= 32'($past(bus_rated_in)) * 90;
  endproperty
  a_byp_cause: assert property (p_byp_cause) else $error("bypass closed below threshold");
  property p_trip_coast;
    $rose(fault_relay_out) |-> !drive_enable_out && display_mode_out == dtf_pkg::DISP_SHOW_CODE
      && display_code_out != dtf_pkg::DTF_CODE_NONE;
  endproperty
  a_trip_coast: assert property (p_trip_coast) else $error("trip without coast or code");
  property p_first_code;
    fault_relay_out && $past(fault_relay_out) && display_mode_out == dtf_pkg::DISP_SHOW_CODE
      |-> $stable(display_code_out);
  endproperty
  a_first_code: assert property (p_first_code) else $error("trip code changed");
  property p_no_restart; $fell(fault_relay_out) |-> !drive_enable_out ##1 !drive_enable_out; endproperty
  a_no_restart: assert property (p_no_restart) else $error("ran straight after reset");
  property p_drive_ready; drive_enable_out |-> ready_out && !fault_relay_out; endproperty
  a_drive_ready: assert property (p_drive_ready) else $error("drive on while not ready");
  property p_st_time; ready_out |-> up_reg >= SELFTEST_CYCLES - 1; endproperty
  a_st_time: assert property (p_st_time) else $error("ready before self-test end");
  property p_self_text;
    display_mode_out == dtf_pkg::DISP_SHOW_SELF |-> !ready_out && !fault_relay_out && !drive_enable_out;
  endproperty
  a_self_text: assert property (p_self_text) else $error("self-test text while operating");
  property p_cfg_lock; config_write_ok_out |-> ready_out && !drive_enable_out && !fault_relay_out; endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("config accepted outside stop");
  property p_hist_range; history_index_out <= 2'h2; endproperty
  a_hist_range: assert property (p_hist_range) else $error("history index past oldest");
endmodule

bind dtf_trip_manager dtf_chk #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_chk (
  .core_clk_in, .reset_n_in, .bus_voltage_in, .bus_rated_in, .precharge_bypass_relay_out,
  .fault_relay_out, .drive_enable_out, .ready_out, .config_write_ok_out, .display_mode_out,
  .display_code_out, .history_index_out
);

// file: bench/dtf_plant.sv
// Power stage model: charging bus capacitor and protection sensors.
// Assumes the bench selects the fault to inject by its code number.
`timescale 1ns/100ps
module dtf_plant (
  input  wire logic                      clk_in,
  input  wire logic                      charge_in,
  input  wire logic [3:0]                inject_in,
  output logic [dtf_pkg::BUS_W-1:0]      bus_voltage_out,
  output logic [dtf_pkg::BUS_W-1:0]      bus_rated_out,
  output logic                           high_bus_out,
  output logic                           low_bus_out,
  output logic                           accel_out,
  output logic                           decel_out,
  output logic                           oc_out,
  output logic                           ol_out,
  output logic                           leak_out,
  output logic                           arm_out
);
  assign bus_rated_out = 12'h3e8;
  // Capacitor charges ten counts a cycle up to rated
  always @(posedge clk_in) begin
    if (!charge_in) bus_voltage_out <= 12'h0;
    else if (bus_voltage_out < bus_rated_out) bus_voltage_out <= bus_voltage_out + 12'h00a;
  end
  always_comb begin
    high_bus_out = inject_in == 4'h1;
    low_bus_out = inject_in == 4'h2;
    accel_out = inject_in == 4'h3;
    decel_out = inject_in == 4'h4;
    leak_out = inject_in == 4'h5;
    oc_out = inject_in == 4'h3 || inject_in == 4'h4 || inject_in == 4'h6;
    ol_out = inject_in == 4'h7;
    arm_out = inject_in == 4'h8;
  end
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the trip manager.
// Assumes short self-test and clear-hold counts set below.
`timescale 1ns/100ps
module tb_top;
  localparam int ST = 50;
  localparam int CL = 40;
  logic clk = 1'b0, rst_n = 1'b0, pass = 1'b1, charge = 1'b0, jmp = 1'b0, cfg = 1'b0;
  logic [4:0] keys = 5'h0;
  logic [3:0] inj = 4'h0;
  logic [11:0] volt, rated;
  logic hb, lb, ac, dc, oc, ol, lk, ar, byp, frel, drv, rdy, cok;
  logic [3:0] mode, code;
  logic [7:0] two;
  logic [1:0] hidx;
  logic [7:0] fcode = 8'h5a;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  dtf_plant u_plant (.clk_in(clk), .charge_in(charge), .inject_in(inj), .bus_voltage_out(volt),
    .bus_rated_out(rated), .high_bus_out(hb), .low_bus_out(lb), .accel_out(ac), .decel_out(dc),
    .oc_out(oc), .ol_out(ol), .leak_out(lk), .arm_out(ar));
  dtf_trip_manager #(.SELFTEST_CYCLES(ST), .CLEAR_CYCLES(CL)) u_dut (.core_clk_in(clk), .reset_n_in(rst_n),
    .bus_voltage_in(volt), .bus_rated_in(rated), .selftest_pass_in(pass), .selftest_code_in(fcode),
    .high_bus_in(hb), .low_bus_in(lb), .accelerating_in(ac), .decelerating_in(dc),
    .output_overcurrent_in(oc), .output_overload_in(ol), .leakage_fault_in(lk), .bus_current_fault_in(ar),
    .start_key_in(keys[0]), .stop_key_in(keys[1]), .monitor_key_in(keys[2]), .up_key_in(keys[3]),
    .down_key_in(keys[4]), .program_enable_jumper_position_in(jmp), .config_write_in(cfg),
    .precharge_bypass_relay_out(byp), .fault_relay_out(frel), .drive_enable_out(drv), .ready_out(rdy),
    .config_write_ok_out(cok), .display_mode_out(mode), .display_code_out(code),
    .two_digit_code_out(two), .history_index_out(hidx));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic key(input int k, input int hold);
    keys[k] = 1'b1;
    wait_n(hold);
    keys[k] = 1'b0;
    wait_n(10);
  endtask
  task automatic do_reset(input logic ok, output int n);
    n = 0;
    rst_n = 1'b0;
    pass = ok;
    wait_n(8);
    rst_n = 1'b1;
    while (rdy !== 1'b1 && n < ST + 20) begin
      wait_n(1);
      n++;
    end
  endtask
  task automatic t_self_fail;
    int n;
    do_reset(1'b0, n);
    chk(mode, dtf_pkg::DISP_SHOW_SELF);
    fcode = 8'hc3;
    key(0, 3);
    chk(two, 8'h5a);
    chk(drv, 1'b0);
  endtask
  task automatic t_power_up;
    int n;
    do_reset(1'b1, n);
    chk(n >= ST - 2 && n <= ST + 8, 1'b1);
    charge = 1'b1;
    for (int i = 0; i < 200 && volt !== 12'h37a; i++) wait_n(1);
    chk(byp, 1'b0);
    for (int i = 0; i < 20 && volt !== 12'h384; i++) wait_n(1);
    wait_n(2);
    chk(byp, 1'b1);
  endtask
  task automatic t_trips;
    for (int i = 1; i <= 8; i++) begin
      key(0, 3);
      chk(drv, 1'b1);
      inj = 4'(i);
      wait_n(8);
      chk({frel, drv}, 2'b10);
      chk(mode, dtf_pkg::DISP_SHOW_CODE);
      chk(code, 12'(i));
      inj = (i == 5) ? 4'h1 : 4'h5;
      wait_n(8);
      chk(code, 12'(i));
      key(0, 3);
      chk(drv, 1'b0);
      inj = 4'h0;
      key(1, 3);
      chk({frel, rdy, drv}, 3'b010);
    end
  endtask
  task automatic t_config;
    cfg = 1'b1;
    wait_n(8);
    chk(cok, 1'b0);
    jmp = 1'b1;
    wait_n(8);
    chk(cok, 1'b1);
    key(0, 3);
    chk(cok, 1'b0);
    key(2, 3);
    chk(mode == dtf_pkg::DISP_SHOW_HIST, 1'b0);
    key(1, 3);
    cfg = 1'b0;
    jmp = 1'b0;
  endtask
  task automatic t_history;
    key(2, 3);
    chk({mode, hidx, code}, {dtf_pkg::DISP_SHOW_HIST, 2'h0, 4'h8});
    key(4, 3);
    chk({hidx, code}, {2'h1, 4'h7});
    key(4, 3);
    chk({hidx, code}, {2'h2, 4'h6});
    key(3, 3);
    chk({hidx, code}, {2'h1, 4'h7});
    key(0, 3);
  endtask
  task automatic t_clear;
    inj = 4'h5;
    wait_n(8);
    chk(code, 4'h5);
    inj = 4'h0;
    keys[1] = 1'b1;
    wait_n(CL + 10);
    chk(mode, dtf_pkg::DISP_SHOW_ZERO);
    keys[1] = 1'b0;
    wait_n(10);
    chk(frel, 1'b0);
    key(2, 3);
    chk(code, 4'h0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    @(negedge clk);
    t_self_fail();
    t_power_up();
    t_trips();
    t_config();
    t_history();
    t_clear();
    summarize();
  end
endmodule
